// ==== hw/asr_pkg.sv ====
package asr_pkg;

    localparam int  ADDR_W      = 14;
    localparam int  CLK_MHZ     = 40;
    localparam int  CLK_PS      = 25000;

    // Power-up lockout and the slowest speed grade's figures
    localparam int  PWRUP_US    = 2000;
    localparam int  ACC_E_NS    = 70;
    localparam int  ACC_A_NS    = 65;
    localparam int  WR_PULSE_NS = 30;
    localparam int  ADR_SU_NS   = 8;
    localparam int  ADR_HD_NS   = 10;
    localparam int  DAT_HD_NS   = 10;
    localparam int  CYC_NS      = 65;

    // Least times round up to whole cycles
    function automatic int cyc_up(input int ns);
        cyc_up = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        if (cyc_up < 1) begin
            cyc_up = 1;
        end
    endfunction : cyc_up

    localparam int  PWRUP_CYC   = PWRUP_US * CLK_MHZ;
    localparam int  RD_CYC      = cyc_up(ACC_E_NS) + 1;
    localparam int  WR_CYC      = cyc_up(CYC_NS);
    localparam int  SU_CYC      = cyc_up(ADR_SU_NS);
    localparam int  HD_CYC      = cyc_up(ADR_HD_NS > DAT_HD_NS ? ADR_HD_NS : DAT_HD_NS);
    localparam int  CNT_W       = 8;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic              data;
    } asr_req_t;

    typedef struct packed {
        logic              selN;
        logic              wrN;
        logic [ADDR_W-1:0] addr;
        logic              din;
    } asr_pins_t;

    typedef enum logic [2:0] {
        ST_PWRUP  = 3'b000,
        ST_IDLE   = 3'b001,
        ST_RDWAIT = 3'b010,
        ST_WSETUP = 3'b011,
        ST_WPULSE = 3'b100,
        ST_WHOLD  = 3'b101
    } asr_state_t;

endpackage : asr_pkg

// ==== hw/asr_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module asr_sync
    import asr_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic async_i,
    output logic      sync_o
);
    logic stage1_q;

    // Only the second stage is read outside
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_q <= 1'b0;
            sync_o   <= 1'b0;
        end else begin
            stage1_q <= async_i;
            sync_o   <= stage1_q;
        end
    end
endmodule : asr_sync
`default_nettype wire

// ==== hw/asr_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module asr_host
    import asr_pkg::*;
#(
    parameter int PWRUP_CYCLES = PWRUP_CYC
)(
    input  wire logic  clk,
    input  wire logic  reset_n,
    input  wire logic  reqValid,
    output logic       reqReady,
    input  wire asr_req_t req,
    output logic       rspValid,
    output logic       rspData,
    output asr_pins_t  pins,
    input  wire logic  memDout
);
    ////////////////////////////////////////////////////////////////////
    asr_state_t        state_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [31:0]       pwr_q;
    logic              doutSync;
    logic              selN_q;
    logic              wrN_q;
    logic [ADDR_W-1:0] addr_q;
    logic              din_q;

    // Last wait cycle of a read, one past the synchroniser delay
    function automatic logic rd_last(input asr_state_t s, input logic [CNT_W-1:0] c);
        rd_last = (s == ST_RDWAIT) && (c == CNT_W'(RD_CYC + 1));
    endfunction : rd_last

    asr_sync u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .async_i (memDout),
        .sync_o  (doutSync)
    );

    assign reqReady = (state_q == ST_IDLE);
    assign pins     = '{selN: selN_q, wrN: wrN_q, addr: addr_q, din: din_q};

    ////////////////////////////////////////////////////////////////////
    // Lockout counter; requests wait until the device can be selected
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_q <= 32'h0000_0000;
        end else if (pwr_q < 32'(PWRUP_CYCLES)) begin
            pwr_q <= pwr_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_PWRUP;
            cnt_q   <= '0;
        end else begin
            unique case (state_q)
                ST_PWRUP: begin
                    if (pwr_q >= 32'(PWRUP_CYCLES)) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (reqValid) begin
                        cnt_q   <= '0;
                        state_q <= req.wr ? ST_WSETUP : ST_RDWAIT;
                    end
                end
                ST_RDWAIT: begin
                    // Two extra cycles cover the two-stage input synchroniser
                    cnt_q <= cnt_q + 1'b1;
                    if (rd_last(state_q, cnt_q)) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_WSETUP: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(SU_CYC - 1)) begin
                        cnt_q   <= '0;
                        state_q <= ST_WPULSE;
                    end
                end
                ST_WPULSE: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(WR_CYC - 1)) begin
                        cnt_q   <= '0;
                        state_q <= ST_WHOLD;
                    end
                end
                ST_WHOLD: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(HD_CYC - 1)) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address and data latched once per access, never changed mid-write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_q <= '0;
            din_q  <= 1'b0;
        end else if (state_q == ST_IDLE && reqValid) begin
            addr_q <= req.addr;
            din_q  <= req.data;
        end
    end

    // Select held low over the whole access
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            selN_q <= 1'b1;
        end else begin
            selN_q <= !(state_q == ST_RDWAIT || state_q == ST_WSETUP ||
                        state_q == ST_WPULSE || state_q == ST_WHOLD ||
                        (state_q == ST_IDLE && reqValid));
        end
    end

    // Strobe ends the write before select rises
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrN_q <= 1'b1;
        end else begin
            wrN_q <= !(state_q == ST_WSETUP && cnt_q == CNT_W'(SU_CYC - 1) ||
                       state_q == ST_WPULSE && cnt_q != CNT_W'(WR_CYC - 1));
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rspValid <= 1'b0;
        end else begin
            rspValid <= rd_last(state_q, cnt_q);
        end
    end

    // Data held until the next read answer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rspData <= 1'b0;
        end else if (rd_last(state_q, cnt_q)) begin
            rspData <= doutSync;
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_addr_stable: assert property (@(posedge clk) disable iff (!reset_n)
        !pins.wrN || !$past(pins.wrN) |-> $stable(pins.addr))
        else $error("Address moved during access");
    a_strobe_in_sel: assert property (@(posedge clk) disable iff (!reset_n)
        !pins.wrN |-> !pins.selN && !$past(pins.selN))
        else $error("Strobe low without prior select");
    a_hold_after_wr: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(pins.wrN) |-> !pins.selN)
        else $error("Select rose with strobe");
    a_pwrup_idle: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_PWRUP |-> pins.selN)
        else $error("Selected during lockout");
    a_read_resp: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_IDLE && reqValid && !req.wr |-> ##(RD_CYC + 3) rspValid)
        else $error("Read answer late");
    a_read_no_wr: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_RDWAIT |-> pins.wrN)
        else $error("Strobe low in read");
    a_wr_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(pins.wrN) |-> !pins.wrN [*2])
        else $error("Write pulse too short");
    a_din_stable: assert property (@(posedge clk) disable iff (!reset_n)
        !pins.wrN || !$past(pins.wrN) |-> $stable(pins.din))
        else $error("Data moved during access");
    a_sel_after_wr: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(pins.selN) |-> $past(pins.wrN))
        else $error("Select rose before strobe");
    a_sel_rise_hold: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(pins.selN) |-> $stable(pins.addr) && $stable(pins.din))
        else $error("Address or data moved at select rise");
    a_wr_len: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(pins.wrN) |-> $past(!pins.wrN, WR_CYC))
        else $error("Write strobe shorter than cycle");
    a_rsp_one: assert property (@(posedge clk) disable iff (!reset_n)
        rspValid |=> !rspValid)
        else $error("Answer stood more than one cycle");
    a_lock_ready: assert property (@(posedge clk) disable iff (!reset_n)
        pwr_q < 32'(PWRUP_CYCLES) |-> !reqReady && pins.selN)
        else $error("Ready during lockout");
    a_take_sel: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_IDLE && reqValid |=> !pins.selN && pins.wrN && pins.addr == $past(req.addr))
        else $error("Address not with select fall");
    a_rd_sel: assert property (@(posedge clk) disable iff (!reset_n)
        rd_last(state_q, cnt_q) |-> !pins.selN && pins.wrN)
        else $error("Read sample outside selection");
    a_idle_desel: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_IDLE && !reqValid |=> pins.selN && pins.wrN)
        else $error("Selected while idle");
    c_read: cover property (@(posedge clk) disable iff (!reset_n) rspValid);
    c_write: cover property (@(posedge clk) disable iff (!reset_n) $rose(pins.wrN));
    c_b2b: cover property (@(posedge clk) disable iff (!reset_n)
        rspValid ##1 (reqValid && reqReady));
    c_lock_done: cover property (@(posedge clk) disable iff (!reset_n) $rose(reqReady));
endmodule : asr_host
`default_nettype wire

// ==== test/asr_sram_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module asr_sram_model
    import asr_pkg::*;
#(
    parameter int LOCK_NS = 400
)(
    input  wire logic              selN,
    input  wire logic              wrN,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              din,
    output logic                   dout,
    output logic                   doutEn
);
    logic mem [0:(1<<ADDR_W)-1];
    logic ready;
    logic valQ;
    logic lastQ;
    ////////////////////////////////////////////////////////////////
    // Short lockout stands in for supply ramp
    initial begin
        ready = 1'b0;
        lastQ = 1'b0;
        #(LOCK_NS) ready = 1'b1;
    end
    // Store on whichever strobe rises first
    always @(posedge selN or posedge wrN) begin
        if (ready && !(selN && wrN)) begin
            mem[addr] = din;
        end
    end
    // One delay, started by a change of address or of the addressed cell; select fall adds none
    assign #(ACC_A_NS) valQ = mem[addr];
    assign doutEn = ready && !selN && wrN;
    always @(doutEn or valQ) begin
        if (doutEn) begin
            lastQ = valQ;
        end
    end
    // Released line shows inverse, never stale data
    assign dout = doutEn ? valQ : ~lastQ;
endmodule : asr_sram_model
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    import asr_pkg::*;
    logic      clk = 1'b0;
    logic      resetN;
    logic      reqValid;
    logic      reqReady;
    logic      rspValid;
    logic      rspData;
    logic      memDout;
    asr_req_t  req;
    asr_pins_t pins;
    int        miscompares = 0;
    int        compares = 0;
    localparam int LOCK_CYC = 20;
    always #12.5 clk = ~clk;
    asr_host #(.PWRUP_CYCLES(LOCK_CYC)) dut (.clk(clk), .reset_n(resetN), .reqValid(reqValid),
        .reqReady(reqReady), .req(req), .rspValid(rspValid), .rspData(rspData),
        .pins(pins), .memDout(memDout));
    asr_sram_model mem (.selN(pins.selN), .wrN(pins.wrN), .addr(pins.addr),
        .din(pins.din), .dout(memDout), .doutEn());
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic got, input logic exp, input string msg);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk
    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic d);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 100) begin
            @(posedge clk); #1;
            n++;
        end
        reqValid = 1'b1;
        req = '{wr, a, d};
        @(posedge clk); #1;
        reqValid = 1'b0;
    endtask : issue
    task automatic do_write(input logic [ADDR_W-1:0] a, input logic d);
        int   lowCnt;
        logic prevLow;
        lowCnt = 0;
        prevLow = 1'b0;
        issue(1'b1, a, d);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk); #1;
            if (pins.wrN === 1'b0) begin
                lowCnt++;
                chk(pins.addr === a && pins.din === d, 1'b1, "addr/din moved");
            end else if (prevLow) begin
                chk(pins.selN, 1'b0, "select rose first");
            end
            prevLow = (pins.wrN === 1'b0);
        end
        chk(lowCnt >= cyc_up(WR_PULSE_NS), 1'b1, "strobe too short");
    endtask : do_write
    task automatic do_read(input logic [ADDR_W-1:0] a, input logic exp);
        int n;
        n = 0;
        issue(1'b0, a, 1'b0);
        while (rspValid !== 1'b1 && n < 20) begin
            @(posedge clk); #1;
            n++;
        end
        chk(n == RD_CYC + 2, 1'b1, "read latency");
        chk(rspData, exp, "read data");
        @(posedge clk);
        #1;
        chk(rspValid, 1'b0, "answer stood too long");
        @(posedge clk);
        #1;
        chk(pins.selN, 1'b1, "not deselected");
    endtask : do_read
    task automatic complete_run;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////
    // Nothing selected and no request taken during lockout
    task automatic test_lockout;
        repeat (4) @(posedge clk);
        #1;
        chk(pins.selN & pins.wrN, 1'b1, "strobes low in reset");
        resetN = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk(reqReady, 1'b0, "ready during lockout");
        chk(pins.selN, 1'b1, "selected during lockout");
        repeat (LOCK_CYC - 10) @(posedge clk);
        #1;
        chk(reqReady, 1'b0, "ready too early");
        @(posedge clk);
        #1;
        chk(reqReady, 1'b1, "not ready after lockout");
    endtask : test_lockout
    // Boundary and checker addresses, writes then reads, each finished before the next is issued
    task automatic test_walk;
        logic [ADDR_W-1:0] al [6] = '{14'h0000, 14'h0001, 14'h3ffe, 14'h3fff,
                                      14'h2aaa, 14'h1555};
        for (int i = 0; i < 6; i++) do_write(al[i], i[0]);
        for (int i = 0; i < 6; i++) do_read(al[i], i[0]);
    endtask : test_walk
    // Overwrite one cell from one to zero, then its neighbour from zero to one; neighbour left alone by the first
    task automatic test_overwrite;
        do_write(14'h0100, 1'b1);
        do_write(14'h0101, 1'b0);
        do_write(14'h0100, 1'b0);
        do_read(14'h0100, 1'b0);
        do_read(14'h0101, 1'b0);
        do_write(14'h0101, 1'b1);
        do_read(14'h0101, 1'b1);
    endtask : test_overwrite
    // Second read follows the answer at once; select stays low
    task automatic test_b2b;
        int n;
        n = 0;
        do_write(14'h2aab, 1'b1);
        issue(1'b0, 14'h2aab, 1'b0);
        while (rspValid !== 1'b1 && n < 20) begin
            @(posedge clk); #1;
            n++;
        end
        chk(rspData, 1'b1, "first read of pair");
        issue(1'b0, 14'h0000, 1'b0);
        chk(pins.selN, 1'b0, "select rose between reads");
        n = 0;
        while (rspValid !== 1'b1 && n < 20) begin
            @(posedge clk); #1;
            n++;
        end
        chk(n == RD_CYC + 2, 1'b1, "second read latency");
        chk(rspData, 1'b0, "second read data");
        do_read(14'h2aab, 1'b1);
    endtask : test_b2b
    initial begin
        resetN = 1'b0;
        reqValid = 1'b0;
        req = '0;
        test_lockout();
        test_walk();
        test_overwrite();
        test_b2b();
        complete_run();
    end
    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
